/* verilog/gpt_timer.sv */
// General timer module: 32-bit one-shot/periodic and RTC modes, AHB-Lite slave.
// Assumes one mclk domain; capture pin and debug halt arrive asynchronously.
// Functional notes
// - Two 16-bit halves, joined as 32-bit timer or RTC; split, they are held but not counted.
// - Converter triggers of all timer blocks are ORed outside into one.
// - Reset: inactive, controls cleared, counters and load registers 0xffff.
// - Both prescale registers reset to zero.
// - Config 0 selects 32-bit timer, 1 selects 32-bit RTC.
// - Config 4 selects split 16-bit halves, each configured independently.
// - 32-bit load write fills half A low, half B high.
// - 32-bit count read returns half B high, half A low.
// - Half A mode field alone picks one-shot or periodic; B ignored.
// - Enabled timer counts down, reloads from joined load value after zero.
// - One-shot stops and clears enable at zero; periodic keeps counting.
// - Zero sets raw time-out flag until software clears it.
// - Masked time-out flag follows raw when unmasked.
// - Converter trigger pulses at zero only when trigger enable set.
// - Rewriting the load value while running loads it next cycle.
// - Stall bit freezes timer counting during debug halt; RTC counting never stalls.
// - RTC counts up, loaded with one at first selection; reloads via match.
// - RTC input is 32.768 kHz on even capture pin, divided to 1 Hz.
// - RTC rolls to zero on match, counts until reset or disable.
// - RTC match sets raw flag, and masked flag when unmasked; clear bit clears both.
// - RTC enable overrides debug stall bits.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module gpt_timer
  import gpt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        capture_compare_pin,
  input  wire logic        debug_halt,
  output logic             conv_trigger
);
  typedef enum logic [1:0] {
    GPT_ST_IDLE = 2'b01,
    GPT_ST_RUN  = 2'b10
  } gpt_state_t;

  gpt_state_t  st_reg, st_next;
  logic [2:0]  cfg_reg, cfg_next;
  logic [1:0]  amode_reg, amode_next;
  logic [1:0]  bmode_reg, bmode_next;
  logic [CTL_W-1:0] ctl_reg, ctl_next;
  logic [IRQ_W-1:0] imr_reg, imr_next;
  logic [IRQ_W-1:0] ris_reg, ris_next;
  logic [15:0] ailr_reg, ailr_next;
  logic [15:0] bilr_reg, bilr_next;
  logic [31:0] match_reg, match_next;
  logic [7:0]  apr_reg, apr_next;
  logic [7:0]  bpr_reg, bpr_next;
  logic [31:0] cnt_reg, cnt_next;
  logic        rtc_loaded_reg, rtc_loaded_next;
  logic        trig_reg, trig_next;
  logic [31:0] rdata_reg, rdata_next;
  // Bus data-phase capture
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  wr_addr_reg, wr_addr_next;
  logic [2:0]  halt_sync_reg;
  logic        halt_reg, halt_next;
  logic        rtc_tick;
  logic        is32, rtc_mode, stall, zero_ev, match_ev, wr_now, rd_now, load_wr;
  logic [31:0] wd;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  gpt_rtc_div u_div (
    .mclk   (mclk),
    .arst_n (arst_n),
    .pin_in (capture_compare_pin),
    .run    (rtc_mode && ctl_reg[CTL_AEN]),
    .tick   (rtc_tick)
  );

  always_comb begin
    is32     = (cfg_reg != CFG_16_SPLIT);
    rtc_mode = (cfg_reg == CFG_32_RTC);
    // RTC enable beats the debug stall bits
    stall    = halt_reg && ctl_reg[CTL_ASTALL] && !ctl_reg[CTL_CLOCK_MODE_ENABLE];
    wr_now   = wr_pend_reg;
    wd       = hwdata;
    rd_now   = hsel && hready && htrans[1] && !hwrite;
    load_wr  = wr_now && hit(wr_addr_reg, ADDR_AILR);
    zero_ev  = 1'b0;
    match_ev = 1'b0;
    halt_next = halt_reg;
    if (halt_sync_reg[1] == halt_sync_reg[2]) begin
      halt_next = halt_sync_reg[2];
    end
    wr_pend_next = hsel && hready && htrans[1] && hwrite;
    wr_addr_next = haddr[7:0];

    cfg_next   = cfg_reg;
    amode_next = amode_reg;
    bmode_next = bmode_reg;
    ctl_next   = ctl_reg;
    imr_next   = imr_reg;
    ailr_next  = ailr_reg;
    bilr_next  = bilr_reg;
    match_next = match_reg;
    apr_next   = apr_reg;
    bpr_next   = bpr_reg;
    rtc_loaded_next = rtc_loaded_reg;
    cnt_next   = cnt_reg;
    st_next    = st_reg;
    trig_next  = 1'b0;

    // Counter engine; 16-bit split modes are held only, not counted here
    case (st_reg)
      GPT_ST_IDLE: begin
        if (ctl_reg[CTL_AEN] && is32) begin
          st_next = GPT_ST_RUN;
        end
      end
      GPT_ST_RUN: begin
        if (!ctl_reg[CTL_AEN] || !is32) begin
          st_next = GPT_ST_IDLE;
        end else if (rtc_mode) begin
          if (rtc_tick) begin
            if (cnt_reg == match_reg) begin
              cnt_next = ZERO32;
              match_ev = 1'b1;
            end else begin
              cnt_next = cnt_reg + 32'h0000_0001;
            end
          end
        end else if (!stall) begin
          if (cnt_reg == ZERO32) begin
            zero_ev  = 1'b1;
            cnt_next = {bilr_reg, ailr_reg};
            trig_next = ctl_reg[CTL_AOTE];
            if (amode_reg != MODE_PERIODIC) begin
              ctl_next[CTL_AEN] = 1'b0;
              st_next = GPT_ST_IDLE;
            end
          end else begin
            cnt_next = cnt_reg - 32'h0000_0001;
          end
        end
      end
      default: st_next = GPT_ST_IDLE;
    endcase

    if (!rtc_mode) begin
      rtc_loaded_next = 1'b0;
    end else if (!rtc_loaded_reg) begin
      cnt_next = RTC_FIRST;
      rtc_loaded_next = 1'b1;
    end

    // Register writes (data phase)
    if (wr_now) begin
      case (wr_addr_reg)
        ADDR_CFG:   cfg_next   = wd[2:0];
        ADDR_AMODE: amode_next = wd[1:0];
        ADDR_BMODE: bmode_next = wd[1:0];
        ADDR_CTL:   ctl_next   = wd[CTL_W-1:0];
        ADDR_IMR:   imr_next   = wd[IRQ_W-1:0];
        ADDR_AILR: begin
          ailr_next = wd[15:0];
          if (is32) begin
            bilr_next = wd[31:16];
          end
        end
        ADDR_BILR:   bilr_next  = wd[15:0];
        ADDR_AMATCH: match_next = wd;
        ADDR_APR:    apr_next   = wd[7:0];
        ADDR_BPR:    bpr_next   = wd[7:0];
        default: ;
      endcase
    end
    // New load value takes over the running count next cycle
    if (load_wr && is32 && !rtc_mode && st_reg == GPT_ST_RUN) begin
      cnt_next = is32 ? wd : {cnt_reg[31:16], wd[15:0]};
    end

    // Set wins over the clear in the same cycle
    ris_next = ris_reg;
    if (wr_now && hit(wr_addr_reg, ADDR_ICR)) begin
      ris_next = ris_reg & ~wd[IRQ_W-1:0];
    end
    if (zero_ev) begin
      ris_next[IRQ_ATO] = 1'b1;
    end
    if (match_ev) begin
      ris_next[IRQ_RTC] = 1'b1;
    end

    rdata_next = 32'h0000_0000;
    if (rd_now) begin
      case (haddr[7:0])
        ADDR_CFG:    rdata_next = {29'h0, cfg_reg};
        ADDR_AMODE:  rdata_next = {30'h0, amode_reg};
        ADDR_BMODE:  rdata_next = {30'h0, bmode_reg};
        ADDR_CTL:    rdata_next = {22'h0, ctl_reg};
        ADDR_IMR:    rdata_next = {28'h0, imr_reg};
        ADDR_RIS:    rdata_next = {28'h0, ris_reg};
        ADDR_MIS:    rdata_next = {28'h0, ris_reg & imr_reg};
        ADDR_AILR:   rdata_next = is32 ? {bilr_reg, ailr_reg} : {16'h0, ailr_reg};
        ADDR_BILR:   rdata_next = {16'h0, bilr_reg};
        ADDR_AMATCH: rdata_next = match_reg;
        ADDR_APR:    rdata_next = {24'h0, apr_reg};
        ADDR_BPR:    rdata_next = {24'h0, bpr_reg};
        ADDR_ACOUNT: rdata_next = is32 ? cnt_reg : {16'h0, cnt_reg[15:0]};
        ADDR_BCOUNT: rdata_next = {16'h0, cnt_reg[31:16]};
        default:     rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg         <= GPT_ST_IDLE;
      cfg_reg        <= CFG_32_TIMER;
      amode_reg      <= 2'h0;
      bmode_reg      <= 2'h0;
      ctl_reg        <= '0;
      imr_reg        <= '0;
      ris_reg        <= '0;
      ailr_reg       <= HALF_RESET;
      bilr_reg       <= HALF_RESET;
      match_reg      <= 32'hffff_ffff;
      apr_reg        <= PRESC_RESET;
      bpr_reg        <= PRESC_RESET;
      cnt_reg        <= {HALF_RESET, HALF_RESET};
      rtc_loaded_reg <= 1'b0;
      trig_reg       <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
      wr_pend_reg    <= 1'b0;
      wr_addr_reg    <= 8'h00;
      halt_sync_reg  <= 3'h0;
      halt_reg       <= 1'b0;
    end else begin
      st_reg         <= st_next;
      cfg_reg        <= cfg_next;
      amode_reg      <= amode_next;
      bmode_reg      <= bmode_next;
      ctl_reg        <= ctl_next;
      imr_reg        <= imr_next;
      ris_reg        <= ris_next;
      ailr_reg       <= ailr_next;
      bilr_reg       <= bilr_next;
      match_reg      <= match_next;
      apr_reg        <= apr_next;
      bpr_reg        <= bpr_next;
      cnt_reg        <= cnt_next;
      rtc_loaded_reg <= rtc_loaded_next;
      trig_reg       <= trig_next;
      rdata_reg      <= rdata_next;
      wr_pend_reg    <= wr_pend_next;
      wr_addr_reg    <= wr_addr_next;
      halt_sync_reg  <= {halt_sync_reg[1:0], debug_halt};
      halt_reg       <= halt_next;
    end
  end

  // Zero-wait slave; OR of triggers across blocks happens at chip level
  assign hrdata       = rdata_reg;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign conv_trigger = trig_reg;

  sequence s_zero_hit;
    st_reg == GPT_ST_RUN && is32 && !rtc_mode && !stall &&
    cnt_reg == ZERO32 && ctl_reg[CTL_AEN];
  endsequence

  // One down-count step of the running 32-bit timer, no bus write in flight
  sequence s_down_step;
    st_reg == GPT_ST_RUN && is32 && !rtc_mode && !stall && ctl_reg[CTL_AEN] &&
    cnt_reg != ZERO32 && !wr_now;
  endsequence

  // Divided tick with the RTC running; no stall term, a halt must not matter
  sequence s_rtc_step;
    st_reg == GPT_ST_RUN && rtc_mode && rtc_loaded_reg && ctl_reg[CTL_AEN] && rtc_tick &&
    !wr_now;
  endsequence

  chk_timeout_raw: assert property (@(posedge mclk) disable iff (!arst_n)
    s_zero_hit |=> ris_reg[IRQ_ATO]) else $error("time-out flag not set");
  chk_flag_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    ris_reg[IRQ_ATO] && !(wr_now && hit(wr_addr_reg, ADDR_ICR)) |=> ris_reg[IRQ_ATO])
    else $error("time-out flag dropped without clear");

  chk_oneshot_stop: assert property (@(posedge mclk) disable iff (!arst_n)
    s_zero_hit ##0 (amode_reg != MODE_PERIODIC) ##0 !wr_now |=> !ctl_reg[CTL_AEN])
    else $error("one-shot kept enable");
  chk_periodic_run: assert property (@(posedge mclk) disable iff (!arst_n)
    s_zero_hit ##0 (amode_reg == MODE_PERIODIC) ##0 !wr_now |=> ctl_reg[CTL_AEN])
    else $error("periodic timer stopped");
  chk_reload_val: assert property (@(posedge mclk) disable iff (!arst_n)
    s_zero_hit ##0 !wr_now |=> cnt_reg == $past({bilr_reg, ailr_reg}))
    else $error("no reload after zero");
  chk_count_down: assert property (@(posedge mclk) disable iff (!arst_n)
    s_down_step |=> cnt_reg == $past(cnt_reg) - 32'h0000_0001)
    else $error("count did not step down");

  chk_trig_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    conv_trigger |-> $past(zero_ev) && $past(ctl_reg[CTL_AOTE]))
    else $error("trigger without enable or zero");
  chk_trig_fire: assert property (@(posedge mclk) disable iff (!arst_n)
    s_zero_hit ##0 ctl_reg[CTL_AOTE] |=> conv_trigger) else $error("trigger missing at zero");
  chk_stall_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    stall && !rtc_mode && !wr_now && st_reg == GPT_ST_RUN |=> $stable(cnt_reg))
    else $error("count moved while stalled");
  chk_split_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    !is32 |=> st_reg == GPT_ST_IDLE) else $error("split mode still counting");

  chk_load_halves: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_now && hit(wr_addr_reg, ADDR_AILR) && is32 |=> {bilr_reg, ailr_reg} == $past(hwdata))
    else $error("joined load not split into halves");
  chk_reload_live: assert property (@(posedge mclk) disable iff (!arst_n)
    load_wr && is32 && !rtc_mode && st_reg == GPT_ST_RUN |=> cnt_reg == $past(hwdata))
    else $error("new load not taken");
  chk_rtc_first: assert property (@(posedge mclk) disable iff (!arst_n)
    rtc_mode && !rtc_loaded_reg |=> cnt_reg == RTC_FIRST) else $error("rtc not preloaded");

  // A tick needs 32768 slow edges, so all but chk_rtc_clear are reached only in long runs
  chk_rtc_roll: assert property (@(posedge mclk) disable iff (!arst_n)
    match_ev |=> cnt_reg == ZERO32 && ris_reg[IRQ_RTC]) else $error("rtc roll wrong");
  chk_rtc_count: assert property (@(posedge mclk) disable iff (!arst_n)
    s_rtc_step ##0 (cnt_reg != match_reg) |=> cnt_reg == $past(cnt_reg) + 32'h0000_0001)
    else $error("rtc count did not advance");
  chk_rtc_flag_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    ris_reg[IRQ_RTC] && !(wr_now && hit(wr_addr_reg, ADDR_ICR)) |=> ris_reg[IRQ_RTC])
    else $error("clock-match flag dropped without clear");
  chk_rtc_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_now && hit(wr_addr_reg, ADDR_ICR) && wd[IRQ_RTC] && !match_ev |=> !ris_reg[IRQ_RTC])
    else $error("clock-match flag not cleared");
endmodule : gpt_timer

/* pkg/gpt_pkg.sv */
// Package for the general timer module: register map, field layout, resets, timing.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package gpt_pkg;
  localparam logic [7:0]  ADDR_CFG     = 8'h00;
  localparam logic [7:0]  ADDR_AMODE   = 8'h04;
  localparam logic [7:0]  ADDR_BMODE   = 8'h08;
  localparam logic [7:0]  ADDR_CTL     = 8'h0c;
  localparam logic [7:0]  ADDR_IMR     = 8'h18;
  localparam logic [7:0]  ADDR_RIS     = 8'h1c;
  localparam logic [7:0]  ADDR_MIS     = 8'h20;
  localparam logic [7:0]  ADDR_ICR     = 8'h24;
  localparam logic [7:0]  ADDR_AILR    = 8'h28;
  localparam logic [7:0]  ADDR_BILR    = 8'h2c;
  localparam logic [7:0]  ADDR_AMATCH  = 8'h30;
  localparam logic [7:0]  ADDR_APR     = 8'h38;
  localparam logic [7:0]  ADDR_BPR     = 8'h3c;
  localparam logic [7:0]  ADDR_ACOUNT  = 8'h48;
  localparam logic [7:0]  ADDR_BCOUNT  = 8'h4c;

  localparam logic [2:0]  CFG_32_TIMER = 3'h0;
  localparam logic [2:0]  CFG_32_RTC   = 3'h1;
  localparam logic [2:0]  CFG_16_SPLIT = 3'h4;

  localparam logic [1:0]  MODE_ONESHOT = 2'h1;
  localparam logic [1:0]  MODE_PERIODIC = 2'h2;

  // Control register bit positions
  localparam int CTL_AEN    = 0;
  localparam int CTL_ASTALL = 1;
  localparam int CTL_CLOCK_MODE_ENABLE  = 4;
  localparam int CTL_AOTE   = 5;
  localparam int CTL_BEN    = 8;
  localparam int CTL_BSTALL = 9;
  localparam int CTL_W      = 10;

  // Status bit positions
  localparam int IRQ_ATO  = 0;
  localparam int IRQ_RTC  = 3;
  localparam int IRQ_W    = 4;

  localparam logic [15:0] HALF_RESET   = 16'hffff;
  localparam logic [7:0]  PRESC_RESET  = 8'h00;
  localparam logic [31:0] RTC_FIRST    = 32'h0000_0001;
  localparam logic [31:0] ZERO32       = 32'h0000_0000;

  localparam int          SYS_CLK_HZ   = 200000000;
  localparam int          RTC_IN_HZ    = 32768;
  localparam int          RTC_OUT_HZ   = 1;
  localparam int          RTC_DIV      = RTC_IN_HZ / RTC_OUT_HZ;
endpackage : gpt_pkg

/* verilog/gpt_rtc_div.sv */
// Divider turning the 32.768 kHz capture pin into a 1 Hz enable.
// Assumes the pin is asynchronous to mclk and far slower than it.
`timescale 1ns/1ps
module gpt_rtc_div
  import gpt_pkg::*;
(
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic pin_in,
  input  wire logic run,
  output logic      tick
);
  logic [2:0]  sync_reg;
  logic [2:0]  sync_next;
  logic        lvl_reg;
  logic        lvl_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;
  logic        rise;

  always_comb begin
    sync_next = {sync_reg[1:0], pin_in};
    lvl_next  = lvl_reg;
    // Change counts once second and third stages agree
    if (sync_reg[1] == sync_reg[2]) begin
      lvl_next = sync_reg[2];
    end
    rise      = lvl_next & ~lvl_reg;
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = 16'h0000;
    end else if (rise) begin
      if (cnt_reg == 16'(RTC_DIV - 1)) begin
        cnt_next  = 16'h0000;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= 3'h0;
      lvl_reg  <= 1'b0;
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      lvl_reg  <= lvl_next;
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  chk_tick_single: assert property (@(posedge mclk) disable iff (!arst_n)
    tick |=> !tick) else $error("rtc tick longer than one cycle");
endmodule : gpt_rtc_div

/* dv/gpt_clk32_src.sv */
// Behavioural slow clock source that stands on the capture pin.
// Assumes the bench gates it with run; the pin idles low between bursts.
`timescale 1ns/1ps
module gpt_clk32_src #(
  parameter realtime HALF_NS = 20.0
) (
  input  wire logic run,
  output logic      pin
);
  // Sped up far beyond 32.768 kHz so a burst fits a short run
  initial begin
    pin = 1'b0;
    #7;
    forever begin
      if (run) begin
        pin = 1'b1;
        #HALF_NS;
        pin = 1'b0;
        #HALF_NS;
      end else begin
        // Stands still low outside bursts
        pin = 1'b0;
        #HALF_NS;
      end
    end
  end
endmodule : gpt_clk32_src

/* dv/gpt_timer_tb.sv */
// Self-checking bench for the general timer module over AHB-Lite.
// Assumes zero-wait slave timing and the slow clock source model beside it.
`timescale 1ns/1ps
module gpt_timer_tb;
  import gpt_pkg::*;
  logic        mclk, arst_n, hsel, hwrite, debug_halt, src_run;
  logic        capture_compare_pin, conv_trigger, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, c1, c2;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          failures, num_checks, trig_cnt, t0;

  gpt_timer u_gpt_timer (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .capture_compare_pin(capture_compare_pin), .debug_halt(debug_halt),
    .conv_trigger(conv_trigger));
  gpt_clk32_src u_gpt_clk32_src (.run(src_run), .pin(capture_compare_pin));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) if (conv_trigger === 1'b1) trig_cnt++;

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // Address phase held until hready, then data phase until hready again
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0000_0000;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask : bus_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0000_0000, q);
    check_val(q & m, exp);
  endtask : rd_chk

  task automatic t_reset;
    rd_chk(ADDR_CFG, 32'h0000_0000, 32'hffff_ffff);
    rd_chk(ADDR_CTL, 32'h0000_0000, 32'hffff_ffff);
    rd_chk(ADDR_ACOUNT, 32'hffff_ffff, 32'hffff_ffff);
    rd_chk(ADDR_BCOUNT, 32'h0000_ffff, 32'h0000_ffff);
    rd_chk(ADDR_AILR, 32'h0000_ffff, 32'h0000_ffff);
    rd_chk(ADDR_BILR, 32'h0000_ffff, 32'h0000_ffff);
    rd_chk(ADDR_APR, 32'h0000_0000, 32'h0000_00ff);
    rd_chk(ADDR_BPR, 32'h0000_0000, 32'h0000_00ff);
    rd_chk(ADDR_AMATCH, 32'hffff_ffff, 32'hffff_ffff);
    rd_chk(8'h80, 32'h0000_0000, 32'hffff_ffff);
    check_val({31'h0, hresp}, 32'h0000_0000);
    $display("test reset_values done");
  endtask : t_reset

  task automatic t_load_cfg;
    wr(ADDR_AILR, 32'h1234_5678);
    rd_chk(ADDR_AILR, 32'h0000_5678, 32'h0000_ffff);
    rd_chk(ADDR_BILR, 32'h0000_1234, 32'h0000_ffff);
    wr(ADDR_APR, 32'h0000_00a5);
    rd_chk(ADDR_APR, 32'h0000_00a5, 32'h0000_00ff);
    wr(8'h80, 32'hdead_beef);
    rd_chk(8'h80, 32'h0000_0000, 32'hffff_ffff);
    wr(ADDR_CFG, 32'h0000_0004);
    rd_chk(ADDR_CFG, 32'h0000_0004, 32'h0000_0007);
    wr(ADDR_CFG, 32'h0000_0000);
    $display("test load_and_config done");
  endtask : t_load_cfg

  task automatic t_oneshot;
    wr(ADDR_AMODE, 32'h0000_0001);
    wr(ADDR_CTL, (32'h1 << CTL_AEN) | (32'h1 << CTL_AOTE));
    t0 = trig_cnt;
    wr(ADDR_AILR, 32'd20);
    repeat (60) @(posedge mclk);
    rd_chk(ADDR_CTL, 32'h0000_0000, 32'h0000_0001);
    rd_chk(ADDR_ACOUNT, 32'd20, 32'hffff_ffff);
    check_val(trig_cnt - t0, 32'd1);
    rd_chk(ADDR_MIS, 32'h0000_0000, 32'h0000_0001);
    repeat (20) @(posedge mclk);
    rd_chk(ADDR_RIS, 32'h0000_0001, 32'h0000_0001);
    wr(ADDR_IMR, 32'h0000_0001);
    rd_chk(ADDR_MIS, 32'h0000_0001, 32'h0000_0001);
    wr(ADDR_ICR, 32'h0000_0001);
    rd_chk(ADDR_RIS, 32'h0000_0000, 32'h0000_0001);
    rd_chk(ADDR_MIS, 32'h0000_0000, 32'h0000_0001);
    $display("test oneshot done");
  endtask : t_oneshot

  task automatic t_periodic;
    // Half B asks for one-shot; only half A's field may count
    wr(ADDR_BMODE, 32'h0000_0001);
    wr(ADDR_AMODE, 32'h0000_0002);
    wr(ADDR_CTL, (32'h1 << CTL_AEN) | (32'h1 << CTL_AOTE) | (32'h1 << CTL_ASTALL));
    wr(ADDR_AILR, 32'd30);
    t0 = trig_cnt;
    repeat (200) @(posedge mclk);
    check_val(32'((trig_cnt - t0) inside {[6:7]}), 32'd1);
    rd_chk(ADDR_CTL, 32'h0000_0001, 32'h0000_0001);
    debug_halt <= 1'b1;
    repeat (10) @(posedge mclk);
    bus_xfer(1'b0, ADDR_ACOUNT, 32'h0, c1);
    repeat (50) @(posedge mclk);
    bus_xfer(1'b0, ADDR_ACOUNT, 32'h0, c2);
    check_val(c2, c1);
    check_val(32'(c2 <= 32'd30), 32'd1);
    debug_halt <= 1'b0;
    repeat (10) @(posedge mclk);
    bus_xfer(1'b0, ADDR_ACOUNT, 32'h0, rd);
    check_val(32'(rd !== c2), 32'd1);
    wr(ADDR_CTL, 32'h1 << CTL_AEN);
    t0 = trig_cnt;
    repeat (100) @(posedge mclk);
    check_val(trig_cnt - t0, 32'd0);
    wr(ADDR_CTL, 32'h0000_0000);
    $display("test periodic_stall done");
  endtask : t_periodic

  task automatic t_rtc;
    wr(ADDR_ICR, 32'h0000_000f);
    wr(ADDR_CFG, 32'h0000_0001);
    rd_chk(ADDR_CFG, 32'h0000_0001, 32'h0000_0007);
    wr(ADDR_CTL, (32'h1 << CTL_AEN) | (32'h1 << CTL_CLOCK_MODE_ENABLE) | (32'h1 << CTL_ASTALL));
    rd_chk(ADDR_ACOUNT, 32'h0000_0001, 32'hffff_ffff);
    // A few hundred edges, far short of one divided tick
    src_run    <= 1'b1;
    debug_halt <= 1'b1;
    repeat (4000) @(posedge mclk);
    src_run    <= 1'b0;
    debug_halt <= 1'b0;
    rd_chk(ADDR_ACOUNT, 32'h0000_0001, 32'hffff_ffff);
    rd_chk(ADDR_RIS, 32'h0000_0000, 32'h0000_0008);
    $display("test rtc_preload done");
  endtask : t_rtc

  task automatic test_done;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    arst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; debug_halt = 1'b0; src_run = 1'b0;
    failures = 0; num_checks = 0; trig_cnt = 0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_load_cfg();
    t_oneshot();
    t_periodic();
    t_rtc();
    test_done();
  end

  // Whole run needs under 6000 cycles; this margin only cuts a hang
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    test_done();
  end
endmodule : gpt_timer_tb
